// ---- pkg/eag_pkg.sv ----
package eag_pkg;

  localparam logic [7:0] BANK_ZERO = 8'h00;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [15:0] WORD_TWO = 16'h0002;
  localparam logic [15:0] WORD_THREE = 16'h0003;

  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR = 3'h4;

  // Width select flags in the processor status byte
  localparam int ACC_WIDTH_BIT = 5;
  localparam int INDEX_WIDTH_BIT = 4;

  localparam logic [15:0] STACK_EMU_LOW = 16'h0100;
  localparam logic [15:0] STACK_EMU_HIGH = 16'h01ff;
  localparam logic [15:0] VEC_LOW_BOUND = 16'hffe0;

  // Vector low-byte addresses, emulation then native
  localparam logic [15:0] VEC_EMU_ABORT = 16'hfff8;
  localparam logic [15:0] VEC_EMU_BRK = 16'hfffe;
  localparam logic [15:0] VEC_EMU_COP = 16'hfff4;
  localparam logic [15:0] VEC_EMU_IRQ = 16'hfffe;
  localparam logic [15:0] VEC_EMU_NMI = 16'hfffa;
  localparam logic [15:0] VEC_EMU_RESET = 16'hfffc;
  localparam logic [15:0] VEC_NAT_ABORT = 16'hffe8;
  localparam logic [15:0] VEC_NAT_BRK = 16'hffe6;
  localparam logic [15:0] VEC_NAT_COP = 16'hffe4;
  localparam logic [15:0] VEC_NAT_IRQ = 16'hffee;
  localparam logic [15:0] VEC_NAT_NMI = 16'hffea;
  localparam logic [15:0] VEC_NAT_RESET = 16'hfffc;

  typedef enum logic [4:0] {
    MODE_IMM, MODE_ABS, MODE_ABS_LONG, MODE_DIR, MODE_ACC, MODE_IMPL,
    MODE_DIR_IND_Y, MODE_DIR_IND_LONG_Y, MODE_DIR_X_IND, MODE_DIR_X, MODE_DIR_Y,
    MODE_ABS_X, MODE_ABS_Y, MODE_ABS_LONG_X, MODE_REL, MODE_REL_LONG,
    MODE_ABS_IND, MODE_DIR_IND, MODE_DIR_IND_LONG, MODE_ABS_X_IND, MODE_STACK,
    MODE_PUSH_IND
  } eag_mode_t;

  // Source of a new program bank; only long jumps, long calls and returns use one
  typedef enum logic [2:0] {
    PBR_KEEP, PBR_OPERAND, PBR_POINTER, PBR_PULL_INT, PBR_PULL_LONG
  } eag_pbr_src_t;

  typedef enum logic [2:0] {
    VEC_ABORT, VEC_BRK, VEC_COP, VEC_IRQ, VEC_NMI, VEC_RESET
  } eag_vec_kind_t;

  typedef enum logic [1:0] {
    PULL_IDLE, PULL_LOW, PULL_HIGH
  } eag_pull_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] program_bank_reg;
    logic [7:0] data_bank_reg;
    logic [15:0] direct;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] s;
    logic [15:0] acc;
    logic [7:0] status;
    logic emul;
  } eag_regs_t;

  typedef struct packed {
    eag_mode_t mode;
    eag_pbr_src_t pbr_src;
    logic imm_index;
    logic taken;
    logic push_result;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [7:0] byte4;
    logic [23:0] ptr;
    logic [7:0] pulled_bank;
  } eag_req_t;

  typedef struct packed {
    logic [23:0] ea;
    logic [23:0] ptr_addr;
    logic [23:0] ptr_next;
    logic [23:0] ptr_last;
    logic [15:0] pc_next;
    logic [7:0] pbr_next;
    logic [15:0] operand;
    logic [2:0] length;
    logic extra_cycle;
  } eag_res_t;

  typedef struct packed {
    eag_res_t res;
    logic valid;
    eag_pull_state_t pull;
    logic pull_n;
    logic [23:0] vec_addr;
    logic [15:0] addr;
    logic [7:0] bank;
  } eag_state_t;

endpackage

// ---- rtl/eag_add24.sv ----
`timescale 1ns/1ns
module eag_add24 (
  input wire logic [23:0] i_base,
  input wire logic [15:0] i_addend,
  output logic [23:0] o_sum
);

  logic [24:0] full_sum;

  // Carry ripples into the bank byte; the top carry is dropped
  assign full_sum = {1'b0, i_base} + {9'h000, i_addend};
  assign o_sum = full_sum[23:0];

endmodule // eag_add24

// ---- rtl/eag_core.sv ----
`timescale 1ns/1ns
// How it works
// - Vector pull output low for the two vector-read cycles, else high.
// - Stack address bank zero; emulation confines it to page one.
// - Direct modes add direct base to offset, result in bank zero.
// - Emulation long-indirect and indirect push pointer bytes step into page one.
// - Program bank changes only for jump-long, call-long and return instructions.
// - Data addresses are 24-bit sums; index carries cross bank boundaries.
// - Absolute: operand bytes form low word, data bank the top byte.
// - Absolute long uses three operand bytes; indexed form adds X.
// - Direct operands in bank zero; extra cycle when direct low byte nonzero.
// - Indirect Y: word pointer plus data bank, then add Y.
// - Indirect long: three-byte pointer is the address; Y form adds Y.
// - Indirect and X-preindexed indirect: pointer word, data bank top byte.
// - Direct X or Y indexed: offset, base and index form bank-zero word.
// - Absolute X or Y: index added to data bank and operand word, carry into bank.
// - Taken branch adds signed byte to next-opcode counter, bank untouched.
// - Long relative adds word modulo 65536; branch loads it, push stacks it.
// - Absolute indirect jump reads bank-zero pointer; long form loads bank too.
// - Indexed indirect jump: operand plus X is bank-zero pointer, bank kept.
// - Without a bank bus the top address byte stays internal.
// - Immediate operand is one byte or two by register width.
// - Accumulator and implied forms are one byte and fetch no operand.
// - Vectors come from fixed bank-zero addresses 00ffe0 to 00ffff.
// - Status bit five sets accumulator width, bit four index width.
module eag_core (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire eag_pkg::eag_req_t i_req,
  input wire eag_pkg::eag_regs_t i_regs,
  input wire logic i_bank_bus_en,
  input wire logic i_vec_start,
  input wire eag_pkg::eag_vec_kind_t i_vec_kind,
  output eag_pkg::eag_res_t o_res,
  output logic o_valid,
  output logic [15:0] o_addr,
  output logic [7:0] o_bank,
  output logic o_vector_pull_n,
  output logic [23:0] o_vector_addr
);

  eag_pkg::eag_state_t st;
  eag_pkg::eag_state_t next_st;

  logic acc8;
  logic idx8;
  logic [15:0] x_eff;
  logic [15:0] y_eff;
  logic [15:0] idx_sel;
  logic [15:0] op16;
  logic dir_page_wrap;
  logic [15:0] dir16;
  logic [15:0] dir_idx16;
  logic [15:0] ptr_base16;
  logic long_ptr;
  logic dir_indirect;
  logic ptr_wrap;
  logic [23:0] sum_base;
  logic [15:0] sum_addend;
  logic [23:0] sum_ea;
  logic [15:0] rel_pc;
  logic [15:0] rel_long_pc;
  logic [15:0] vec_base;
  eag_pkg::eag_mode_t mode;

  assign mode = i_req.mode;
  assign acc8 = i_regs.emul | i_regs.status[eag_pkg::ACC_WIDTH_BIT];
  assign idx8 = i_regs.emul | i_regs.status[eag_pkg::INDEX_WIDTH_BIT];
  assign x_eff = idx8 ? {eag_pkg::ZERO_BYTE, i_regs.x[7:0]} : i_regs.x;
  assign y_eff = idx8 ? {eag_pkg::ZERO_BYTE, i_regs.y[7:0]} : i_regs.y;
  assign idx_sel = (mode == eag_pkg::MODE_DIR_Y) ? y_eff : x_eff;
  assign op16 = {i_req.byte3, i_req.byte2};

  assign dir_page_wrap = i_regs.emul && (i_regs.direct[7:0] == eag_pkg::ZERO_BYTE);
  assign dir16 = i_regs.direct + {eag_pkg::ZERO_BYTE, i_req.byte2};
  // indexed direct, page wrap in emulation with aligned base
  assign dir_idx16 = dir_page_wrap ?
      {i_regs.direct[15:8], i_req.byte2 + idx_sel[7:0]} :
      i_regs.direct + {eag_pkg::ZERO_BYTE, i_req.byte2} + idx_sel;

  // absolute pointers sit in bank zero
  assign ptr_base16 = (mode == eag_pkg::MODE_DIR_X_IND) ? dir_idx16 :
                      (mode == eag_pkg::MODE_ABS_IND) ? op16 :
                      (mode == eag_pkg::MODE_ABS_X_IND) ? op16 + x_eff : dir16;
  assign long_ptr = (mode == eag_pkg::MODE_DIR_IND_LONG) ||
                    (mode == eag_pkg::MODE_DIR_IND_LONG_Y) ||
                    (mode == eag_pkg::MODE_PUSH_IND);
  assign dir_indirect = (mode == eag_pkg::MODE_DIR_IND) ||
                        (mode == eag_pkg::MODE_DIR_IND_Y) ||
                        (mode == eag_pkg::MODE_DIR_X_IND);
  // long pointers never wrap in page
  assign ptr_wrap = dir_page_wrap && dir_indirect && !long_ptr;

  assign sum_base =
      (mode == eag_pkg::MODE_DIR_IND_LONG_Y) ? i_req.ptr :
      (mode == eag_pkg::MODE_DIR_IND_Y) ? {i_regs.data_bank_reg, i_req.ptr[15:0]} :
      (mode == eag_pkg::MODE_ABS_LONG_X) ? {i_req.byte4, op16} :
      {i_regs.data_bank_reg, op16};
  assign sum_addend =
      ((mode == eag_pkg::MODE_DIR_IND_LONG_Y) || (mode == eag_pkg::MODE_DIR_IND_Y) ||
       (mode == eag_pkg::MODE_ABS_Y)) ? y_eff :
      ((mode == eag_pkg::MODE_ABS_X) || (mode == eag_pkg::MODE_ABS_LONG_X)) ? x_eff :
      eag_pkg::WORD_ZERO;

  eag_add24 u_add24 (
    .i_base(sum_base),
    .i_addend(sum_addend),
    .o_sum(sum_ea)
  );

  assign rel_pc = i_regs.pc + eag_pkg::WORD_TWO + {{8{i_req.byte2[7]}}, i_req.byte2};
  assign rel_long_pc = i_regs.pc + eag_pkg::WORD_THREE + op16;

  always_comb begin
    case (i_vec_kind)
      eag_pkg::VEC_ABORT: vec_base = i_regs.emul ? eag_pkg::VEC_EMU_ABORT : eag_pkg::VEC_NAT_ABORT;
      eag_pkg::VEC_BRK: vec_base = i_regs.emul ? eag_pkg::VEC_EMU_BRK : eag_pkg::VEC_NAT_BRK;
      eag_pkg::VEC_COP: vec_base = i_regs.emul ? eag_pkg::VEC_EMU_COP : eag_pkg::VEC_NAT_COP;
      eag_pkg::VEC_IRQ: vec_base = i_regs.emul ? eag_pkg::VEC_EMU_IRQ : eag_pkg::VEC_NAT_IRQ;
      eag_pkg::VEC_NMI: vec_base = i_regs.emul ? eag_pkg::VEC_EMU_NMI : eag_pkg::VEC_NAT_NMI;
      default: vec_base = i_regs.emul ? eag_pkg::VEC_EMU_RESET : eag_pkg::VEC_NAT_RESET;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.valid = i_req_valid;
    if (i_req_valid) begin
      next_st.res.ptr_addr = {eag_pkg::BANK_ZERO, ptr_base16};
      next_st.res.ptr_next = ptr_wrap ?
          {eag_pkg::BANK_ZERO, ptr_base16[15:8], ptr_base16[7:0] + eag_pkg::BYTE_ONE} :
          {eag_pkg::BANK_ZERO, ptr_base16 + eag_pkg::WORD_ONE};
      next_st.res.ptr_last = {eag_pkg::BANK_ZERO, ptr_base16 + eag_pkg::WORD_TWO};
      next_st.res.ea = sum_ea;
      next_st.res.operand = eag_pkg::WORD_ZERO;
      next_st.res.extra_cycle = 1'b0;
      next_st.res.length = eag_pkg::LEN_TWO;
      case (mode)
        eag_pkg::MODE_IMM: begin
          if (i_req.imm_index ? idx8 : acc8) begin
            next_st.res.operand = {eag_pkg::ZERO_BYTE, i_req.byte2};
          end else begin
            next_st.res.operand = op16;
            next_st.res.length = eag_pkg::LEN_THREE;
          end
          next_st.res.ea = {i_regs.program_bank_reg, i_regs.pc + eag_pkg::WORD_ONE};
        end
        eag_pkg::MODE_ABS: begin
          next_st.res.ea = {i_regs.data_bank_reg, op16};
          next_st.res.length = eag_pkg::LEN_THREE;
        end
        eag_pkg::MODE_ABS_LONG: begin
          next_st.res.ea = {i_req.byte4, op16};
          next_st.res.length = eag_pkg::LEN_FOUR;
        end
        eag_pkg::MODE_ABS_LONG_X: begin
          next_st.res.length = eag_pkg::LEN_FOUR;
        end
        eag_pkg::MODE_ABS_X, eag_pkg::MODE_ABS_Y: begin
          next_st.res.length = eag_pkg::LEN_THREE;
        end
        eag_pkg::MODE_DIR: begin
          // bank zero and unaligned base penalty
          next_st.res.ea = {eag_pkg::BANK_ZERO, dir16};
          next_st.res.extra_cycle = (i_regs.direct[7:0] != eag_pkg::ZERO_BYTE);
        end
        eag_pkg::MODE_DIR_X, eag_pkg::MODE_DIR_Y: begin
          next_st.res.ea = {eag_pkg::BANK_ZERO, dir_idx16};
          next_st.res.extra_cycle = (i_regs.direct[7:0] != eag_pkg::ZERO_BYTE);
        end
        eag_pkg::MODE_ACC: begin
          next_st.res.operand = acc8 ? {eag_pkg::ZERO_BYTE, i_regs.acc[7:0]} : i_regs.acc;
          next_st.res.length = eag_pkg::LEN_ONE;
          next_st.res.ea = {i_regs.program_bank_reg, i_regs.pc};
        end
        eag_pkg::MODE_IMPL: begin
          next_st.res.length = eag_pkg::LEN_ONE;
          next_st.res.ea = {i_regs.program_bank_reg, i_regs.pc};
        end
        eag_pkg::MODE_DIR_IND_Y, eag_pkg::MODE_DIR_IND_LONG_Y: begin
          next_st.res.extra_cycle = (i_regs.direct[7:0] != eag_pkg::ZERO_BYTE);
        end
        eag_pkg::MODE_DIR_IND, eag_pkg::MODE_DIR_X_IND: begin
          next_st.res.ea = {i_regs.data_bank_reg, i_req.ptr[15:0]};
          next_st.res.extra_cycle = (i_regs.direct[7:0] != eag_pkg::ZERO_BYTE);
        end
        eag_pkg::MODE_DIR_IND_LONG: begin
          next_st.res.ea = i_req.ptr;
          next_st.res.extra_cycle = (i_regs.direct[7:0] != eag_pkg::ZERO_BYTE);
        end
        eag_pkg::MODE_PUSH_IND: begin
          next_st.res.operand = i_req.ptr[15:0];
          next_st.res.ea = {eag_pkg::BANK_ZERO, dir16};
          next_st.res.extra_cycle = (i_regs.direct[7:0] != eag_pkg::ZERO_BYTE);
        end
        eag_pkg::MODE_REL: begin
          next_st.res.ea = {i_regs.program_bank_reg, rel_pc};
        end
        eag_pkg::MODE_REL_LONG: begin
          next_st.res.ea = {i_regs.program_bank_reg, rel_long_pc};
          next_st.res.operand = rel_long_pc;
          next_st.res.length = eag_pkg::LEN_THREE;
        end
        eag_pkg::MODE_ABS_IND, eag_pkg::MODE_ABS_X_IND: begin
          next_st.res.ea = {eag_pkg::BANK_ZERO, ptr_base16};
          next_st.res.length = eag_pkg::LEN_THREE;
        end
        eag_pkg::MODE_STACK: begin
          next_st.res.ea = i_regs.emul ?
              {eag_pkg::BANK_ZERO, eag_pkg::STACK_PAGE, i_regs.s[7:0]} :
              {eag_pkg::BANK_ZERO, i_regs.s};
          next_st.res.length = eag_pkg::LEN_ONE;
        end
        default: begin
          next_st.res.ea = {i_regs.data_bank_reg, op16};
        end
      endcase

      // counter wraps within bank by default
      next_st.res.pc_next = i_regs.pc + {13'h0000, next_st.res.length};
      if ((mode == eag_pkg::MODE_REL) && i_req.taken) begin
        next_st.res.pc_next = rel_pc;
      end
      if ((mode == eag_pkg::MODE_REL_LONG) && !i_req.push_result) begin
        next_st.res.pc_next = rel_long_pc;
      end
      if ((mode == eag_pkg::MODE_ABS_IND) || (mode == eag_pkg::MODE_ABS_X_IND)) begin
        next_st.res.pc_next = i_req.ptr[15:0];
      end
      if ((mode == eag_pkg::MODE_ABS_LONG) && (i_req.pbr_src == eag_pkg::PBR_OPERAND)) begin
        next_st.res.pc_next = op16;
      end

      // only long jumps and returns load the bank
      case (i_req.pbr_src)
        eag_pkg::PBR_OPERAND: next_st.res.pbr_next = i_req.byte4;
        eag_pkg::PBR_POINTER: next_st.res.pbr_next = i_req.ptr[23:16];
        eag_pkg::PBR_PULL_INT: next_st.res.pbr_next =
            i_regs.emul ? i_regs.program_bank_reg : i_req.pulled_bank;
        eag_pkg::PBR_PULL_LONG: next_st.res.pbr_next = i_req.pulled_bank;
        default: next_st.res.pbr_next = i_regs.program_bank_reg;
      endcase

      next_st.addr = next_st.res.ea[15:0];
      // hide the bank byte on the narrow variant
      next_st.bank = i_bank_bus_en ? next_st.res.ea[23:16] : eag_pkg::BANK_ZERO;
    end

    case (st.pull)
      eag_pkg::PULL_IDLE: begin
        if (i_vec_start) begin
          next_st.pull = eag_pkg::PULL_LOW;
          next_st.pull_n = 1'b0;
          next_st.vec_addr = {eag_pkg::BANK_ZERO, vec_base};
        end
      end
      eag_pkg::PULL_LOW: begin
        next_st.pull = eag_pkg::PULL_HIGH;
        next_st.vec_addr = {eag_pkg::BANK_ZERO, st.vec_addr[15:0] + eag_pkg::WORD_ONE};
      end
      default: begin
        next_st.pull = eag_pkg::PULL_IDLE;
        next_st.pull_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.pull_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_res = st.res;
  assign o_valid = st.valid;
  assign o_addr = st.addr;
  assign o_bank = st.bank;
  assign o_vector_pull_n = st.pull_n;
  assign o_vector_addr = st.vec_addr;

  // Helper copies of the request for checking
  eag_pkg::eag_req_t past_req;
  eag_pkg::eag_regs_t past_regs;
  logic past_bank_en;
  logic [24:0] chk_long_x;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      past_req <= '0;
      past_regs <= '0;
      past_bank_en <= 1'b0;
    end else begin
      past_req <= i_req;
      past_regs <= i_regs;
      past_bank_en <= i_bank_bus_en;
    end
  end

  assign chk_long_x = {1'b0, past_req.byte4, past_req.byte3, past_req.byte2} +
      {9'h000, past_regs.status[eag_pkg::INDEX_WIDTH_BIT] | past_regs.emul ?
       {eag_pkg::ZERO_BYTE, past_regs.x[7:0]} : past_regs.x};

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence pull_low_pair;
    (!o_vector_pull_n) [*2];
  endsequence

  vector_pull_pair_a: assert property (
    (i_vec_start && st.pull == eag_pkg::PULL_IDLE) |=> pull_low_pair ##1 o_vector_pull_n)
    else $error("vector pull not low for exactly two cycles");
  vector_addr_zone_a: assert property (
    !o_vector_pull_n |-> (o_vector_addr[23:16] == eag_pkg::BANK_ZERO &&
                          o_vector_addr[15:0] >= eag_pkg::VEC_LOW_BOUND))
    else $error("vector fetch outside fixed vector area");
  stack_emu_page_a: assert property (
    (o_valid && past_req.mode == eag_pkg::MODE_STACK && past_regs.emul) |->
    (o_res.ea >= {eag_pkg::BANK_ZERO, eag_pkg::STACK_EMU_LOW} &&
     o_res.ea <= {eag_pkg::BANK_ZERO, eag_pkg::STACK_EMU_HIGH}))
    else $error("emulation stack address left page one");
  direct_bank_zero_a: assert property (
    (o_valid && (past_req.mode == eag_pkg::MODE_DIR_X ||
                 past_req.mode == eag_pkg::MODE_DIR_Y ||
                 past_req.mode == eag_pkg::MODE_DIR)) |->
    o_res.ea[23:16] == eag_pkg::BANK_ZERO)
    else $error("direct address outside bank zero");
  direct_extra_cycle_a: assert property (
    (o_valid && past_req.mode == eag_pkg::MODE_DIR) |->
    o_res.extra_cycle == (past_regs.direct[7:0] != eag_pkg::ZERO_BYTE))
    else $error("direct extra cycle flag wrong");
  bank_hold_a: assert property (
    (o_valid && past_req.pbr_src == eag_pkg::PBR_KEEP) |->
    o_res.pbr_next == past_regs.program_bank_reg)
    else $error("program bank changed without a long jump");
  branch_target_a: assert property (
    (i_req_valid && i_req.mode == eag_pkg::MODE_REL && i_req.taken) |=>
    o_res.pc_next == past_regs.pc + eag_pkg::WORD_TWO +
                     {{8{past_req.byte2[7]}}, past_req.byte2})
    else $error("taken branch target wrong");
  absolute_form_a: assert property (
    (i_req_valid && i_req.mode == eag_pkg::MODE_ABS) |=>
    o_res.ea == {past_regs.data_bank_reg, past_req.byte3, past_req.byte2})
    else $error("absolute address wrong");
  long_index_wrap_a: assert property (
    (o_valid && past_req.mode == eag_pkg::MODE_ABS_LONG_X) |->
    o_res.ea == chk_long_x[23:0])
    else $error("long indexed sum not wrapped to 24 bits");
  bank_hidden_a: assert property (
    (o_valid && !past_bank_en) |-> o_bank == eag_pkg::BANK_ZERO)
    else $error("bank byte shown without a bank bus");
  pointer_step_a: assert property (
    (o_valid && past_regs.emul && past_req.mode == eag_pkg::MODE_PUSH_IND) |->
    o_res.ptr_next[15:0] == o_res.ptr_addr[15:0] + eag_pkg::WORD_ONE)
    else $error("long pointer wrapped within page");

endmodule // eag_core

// ---- verification/eag_mem_model.sv ----
`timescale 1ns/1ns
// Memory beside the core: returns the three pointer bytes stored at an address
module eag_mem_model (
  input wire logic [23:0] i_addr,
  output logic [23:0] o_data
);
  // Bank byte follows the address so that long pointers differ from short ones
  assign o_data = {i_addr[7:0], 8'hff, 8'hf0};
endmodule // eag_mem_model

// ---- verification/effective_address_generator_tb.sv ----
`timescale 1ns/1ns
module effective_address_generator_tb;
  logic clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req_valid = 1'b0;
  logic i_bank_bus_en = 1'b1;
  logic i_vec_start = 1'b0;
  eag_pkg::eag_vec_kind_t i_vec_kind = eag_pkg::VEC_RESET;
  eag_pkg::eag_req_t req;
  eag_pkg::eag_regs_t regs;
  eag_pkg::eag_res_t o_res;
  logic o_valid;
  logic [15:0] o_addr;
  logic [7:0] o_bank;
  logic o_vector_pull_n;
  logic [23:0] o_vector_addr;
  logic [23:0] pa = 24'h001211;
  logic [23:0] mem_data;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  eag_core DUT (.i_core_clk(clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(req),
    .i_regs(regs), .i_bank_bus_en(i_bank_bus_en), .i_vec_start(i_vec_start),
    .i_vec_kind(i_vec_kind), .o_res(o_res), .o_valid(o_valid), .o_addr(o_addr),
    .o_bank(o_bank), .o_vector_pull_n(o_vector_pull_n), .o_vector_addr(o_vector_addr));

  eag_mem_model mem (.i_addr(pa), .o_data(mem_data));

  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Vector pull: start pulse, two low cycles with both bytes, then high
  task automatic vec(input eag_pkg::eag_vec_kind_t k, input logic [23:0] lo);
    @(posedge clk);
    i_vec_start <= 1'b1;
    i_vec_kind <= k;
    @(posedge clk);
    i_vec_start <= 1'b0;
    @(negedge clk);
    chk({23'h0, o_vector_pull_n}, 24'h0);
    chk(o_vector_addr, lo);
    @(negedge clk);
    chk({23'h0, o_vector_pull_n}, 24'h0);
    chk(o_vector_addr, lo + 24'h000001);
    @(negedge clk);
    chk({23'h0, o_vector_pull_n}, 24'h1);
  endtask

  // One request, result looked at in the answer cycle
  task automatic run(input eag_pkg::eag_mode_t m, input logic [7:0] b2, input logic [7:0] b3,
      input logic [7:0] b4);
    @(posedge clk);
    req.mode <= m;
    req.byte2 <= b2;
    req.byte3 <= b3;
    req.byte4 <= b4;
    req.ptr <= mem_data;
    i_req_valid <= 1'b1;
    @(posedge clk);
    i_req_valid <= 1'b0;
    @(negedge clk);
    chk({23'h0, o_valid}, 24'h1);
  endtask

  initial begin
    req = '0;
    req.mode = eag_pkg::MODE_ABS;
    req.pbr_src = eag_pkg::PBR_KEEP;
    req.taken = 1'b1;
    regs = '0;
    regs.pc = 16'h1000;
    regs.program_bank_reg = 8'h12;
    regs.data_bank_reg = 8'h34;
    regs.x = 16'h0010;
    regs.y = 16'h0020;
    regs.s = 16'h23f0;
    repeat (16) @(posedge clk);
    i_rst <= 1'b0;
    run(eag_pkg::MODE_ABS, 8'hcd, 8'hab, 8'h00);
    chk(o_res.ea, 24'h34abcd);
    chk({o_bank, o_addr}, 24'h34abcd);
    run(eag_pkg::MODE_ABS_X, 8'hf8, 8'hff, 8'h00);
    chk(o_res.ea, 24'h350008);
    run(eag_pkg::MODE_ABS_Y, 8'hf8, 8'hff, 8'h00);
    chk(o_res.ea, 24'h350018);
    run(eag_pkg::MODE_ABS_LONG_X, 8'hf8, 8'hff, 8'hff);
    chk(o_res.ea, 24'h000008);
    regs.direct <= 16'h1201;
    run(eag_pkg::MODE_DIR, 8'h10, 8'h00, 8'h00);
    chk(o_res.ea, 24'h001211);
    chk({23'h0, o_res.extra_cycle}, 24'h1);
    run(eag_pkg::MODE_DIR_IND_Y, 8'h10, 8'h00, 8'h00);
    chk(o_res.ea, 24'h350010);
    run(eag_pkg::MODE_DIR_IND_LONG_Y, 8'h10, 8'h00, 8'h00);
    chk(o_res.ea, 24'h120010);
    run(eag_pkg::MODE_REL, 8'hf0, 8'h00, 8'h00);
    chk({o_res.pbr_next, o_res.pc_next}, 24'h120ff2);
    i_bank_bus_en <= 1'b0;
    run(eag_pkg::MODE_ABS, 8'hcd, 8'hab, 8'h00);
    chk({o_bank, o_addr}, 24'h00abcd);
    regs.emul <= 1'b1;
    run(eag_pkg::MODE_STACK, 8'h00, 8'h00, 8'h00);
    chk(o_res.ea, 24'h0001f0);
    // Emulation with a zero base: pointer stepping and page wrap
    regs.direct <= 16'h0000;
    run(eag_pkg::MODE_PUSH_IND, 8'hff, 8'h00, 8'h00);
    chk(o_res.ptr_next, 24'h000100);
    chk({8'h00, o_res.operand}, 24'h00fff0);
    chk({23'h0, o_res.extra_cycle}, 24'h0);
    run(eag_pkg::MODE_DIR_IND_LONG, 8'hff, 8'h00, 8'h00);
    chk(o_res.ea, 24'h11fff0);
    chk(o_res.ptr_next, 24'h000100);
    run(eag_pkg::MODE_DIR_IND, 8'hff, 8'h00, 8'h00);
    chk(o_res.ea, 24'h34fff0);
    chk(o_res.ptr_next, 24'h000000);
    run(eag_pkg::MODE_DIR_X, 8'hf8, 8'h00, 8'h00);
    chk(o_res.ea, 24'h000008);
    regs.emul <= 1'b0;
    run(eag_pkg::MODE_DIR_Y, 8'hf8, 8'h00, 8'h00);
    chk(o_res.ea, 24'h000118);
    run(eag_pkg::MODE_DIR_X_IND, 8'h10, 8'h00, 8'h00);
    chk(o_res.ptr_addr, 24'h000020);
    chk(o_res.ea, 24'h34fff0);
    // Length in the top three bits, operand in the low word
    run(eag_pkg::MODE_IMM, 8'hcd, 8'hab, 8'h00);
    chk({o_res.length, 5'h00, o_res.operand}, 24'h60abcd);
    regs.status <= 8'h20;
    run(eag_pkg::MODE_IMM, 8'hcd, 8'hab, 8'h00);
    chk({o_res.length, 5'h00, o_res.operand}, 24'h4000cd);
    req.imm_index <= 1'b1;
    run(eag_pkg::MODE_IMM, 8'hcd, 8'hab, 8'h00);
    chk({o_res.length, 5'h00, o_res.operand}, 24'h60abcd);
    req.imm_index <= 1'b0;
    regs.acc <= 16'hbeef;
    run(eag_pkg::MODE_ACC, 8'h00, 8'h00, 8'h00);
    chk({o_res.length, 5'h00, o_res.operand}, 24'h2000ef);
    req.pulled_bank <= 8'h56;
    req.pbr_src <= eag_pkg::PBR_PULL_INT;
    run(eag_pkg::MODE_IMPL, 8'h00, 8'h00, 8'h00);
    chk({o_res.length, 5'h00, o_res.pc_next}, 24'h201001);
    chk({16'h0000, o_res.pbr_next}, 24'h000056);
    req.pbr_src <= eag_pkg::PBR_PULL_LONG;
    run(eag_pkg::MODE_IMPL, 8'h00, 8'h00, 8'h00);
    chk({16'h0000, o_res.pbr_next}, 24'h000056);
    req.pbr_src <= eag_pkg::PBR_OPERAND;
    run(eag_pkg::MODE_ABS_LONG, 8'h56, 8'h34, 8'h78);
    chk(o_res.ea, 24'h783456);
    chk({o_res.pbr_next, o_res.pc_next}, 24'h783456);
    req.pbr_src <= eag_pkg::PBR_POINTER;
    run(eag_pkg::MODE_ABS_IND, 8'h00, 8'h20, 8'h00);
    chk(o_res.ea, 24'h002000);
    chk({o_res.pbr_next, o_res.pc_next}, 24'h11fff0);
    req.pbr_src <= eag_pkg::PBR_KEEP;
    run(eag_pkg::MODE_ABS_X_IND, 8'hf8, 8'hff, 8'h00);
    chk(o_res.ea, 24'h000008);
    chk({o_res.pbr_next, o_res.pc_next}, 24'h12fff0);
    run(eag_pkg::MODE_REL_LONG, 8'h00, 8'hf0, 8'h00);
    chk({o_res.pbr_next, o_res.pc_next}, 24'h120003);
    req.push_result <= 1'b1;
    run(eag_pkg::MODE_REL_LONG, 8'h00, 8'hf0, 8'h00);
    chk({8'h00, o_res.operand}, 24'h000003);
    chk({o_res.pbr_next, o_res.pc_next}, 24'h121003);
    req.taken <= 1'b0;
    run(eag_pkg::MODE_REL, 8'hf0, 8'h00, 8'h00);
    chk({o_res.pbr_next, o_res.pc_next}, 24'h121002);
    chk({23'h0, o_vector_pull_n}, 24'h1);
    vec(eag_pkg::VEC_IRQ, 24'h00ffee);
    vec(eag_pkg::VEC_BRK, 24'h00ffe6);
    vec(eag_pkg::VEC_COP, 24'h00ffe4);
    vec(eag_pkg::VEC_ABORT, 24'h00ffe8);
    vec(eag_pkg::VEC_NMI, 24'h00ffea);
    vec(eag_pkg::VEC_RESET, 24'h00fffc);
    regs.emul <= 1'b1;
    vec(eag_pkg::VEC_IRQ, 24'h00fffe);
    vec(eag_pkg::VEC_BRK, 24'h00fffe);
    vec(eag_pkg::VEC_COP, 24'h00fff4);
    vec(eag_pkg::VEC_ABORT, 24'h00fff8);
    vec(eag_pkg::VEC_NMI, 24'h00fffa);
    vec(eag_pkg::VEC_RESET, 24'h00fffc);
    print_verdict();
  end
endmodule // effective_address_generator_tb
